// ---- design/fj_pkg.sv ----
// Package with register map, field layout and result types of the judgement block.
package fj_pkg;
   // ========================================
   // Widths
   localparam int VAL_W  = 16;
   localparam int JOB_W  = 7;
   localparam int NLIM   = 25;
   localparam int FAIL_W = 25;
   localparam int INT_W  = 3;
   // ========================================
   // Register byte offsets
   localparam logic [11:0] CTRL_OFS     = 12'h000;
   localparam logic [11:0] FAIL_OFS     = 12'h004;
   localparam logic [11:0] INT_STAT_OFS = 12'h008;
   localparam logic [11:0] INT_MASK_OFS = 12'h00c;
   localparam logic [11:0] RESULT_OFS   = 12'h010;
   localparam logic [11:0] LIMIT_BASE   = 12'h040;
   // ========================================
   // Control register fields
   localparam int CTRL_SEAT_MON = 0;
   localparam int CTRL_SEAT_CUR = 1;
   localparam int CTRL_FIN_CUR  = 2;
   localparam int CTRL_RUNDOWN  = 3;
   localparam int CTRL_SELFTAP  = 4;
   localparam int CTRL_FIN_MON  = 5;
   localparam int CTRL_MULTI    = 6;
   localparam int CTRL_STN_LSB  = 8;
   localparam int STN_W         = 8;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0100;
   localparam logic [STN_W-1:0] MASTER_STATION = 8'h01;
   // ========================================
   // Interrupt status bits
   localparam int INT_COMPLETE = 0;
   localparam int INT_FAIL     = 1;
   localparam int INT_COMBINED = 2;
   localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
   // ========================================
   // Limit indices, one word apart upward from LIMIT_BASE
   localparam int L_SEAT_MAX   = 0;
   localparam int L_TRQ_MAX    = 1;
   localparam int L_TRQ_MIN    = 2;
   localparam int L_ANG_MAX    = 3;
   localparam int L_ANG_MIN    = 4;
   localparam int L_PRESEAT_T  = 5;
   localparam int L_FMIN_T     = 6;
   localparam int L_FMAX_T     = 7;
   localparam int L_TOTAL_T    = 8;
   localparam int L_SMON_MAX   = 9;
   localparam int L_SMON_MIN   = 10;
   localparam int L_SCUR_MAX   = 11;
   localparam int L_SCUR_MIN   = 12;
   localparam int L_FCUR_MAX   = 13;
   localparam int L_FCUR_MIN   = 14;
   localparam int L_PEAK_MAX   = 15;
   localparam int L_PEAK_MIN   = 16;
   localparam int L_RUN_MAX    = 17;
   localparam int L_RUN_MIN    = 18;
   localparam int L_STAP_MAX   = 19;
   localparam int L_STAP_MIN   = 20;
   localparam int L_FMON_MAX   = 21;
   localparam int L_FMON_MIN   = 22;
   localparam int L_SPARE0     = 23;
   localparam int L_SPARE1     = 24;
   localparam logic [VAL_W-1:0] LIMIT_RST = 16'h0000;
   // ========================================
   // Types
   typedef struct packed {
      logic [VAL_W-1:0] seat_torque;
      logic [VAL_W-1:0] torque;
      logic [VAL_W-1:0] peak_torque;
      logic [VAL_W-1:0] angle;
      logic [VAL_W-1:0] rundown_angle;
      logic [VAL_W-1:0] preseat_time;
      logic [VAL_W-1:0] finish_time;
      logic [VAL_W-1:0] total_time;
      logic [VAL_W-1:0] seat_monitor_torque;
      logic [VAL_W-1:0] seat_current;
      logic [VAL_W-1:0] final_current;
      logic [VAL_W-1:0] selftap_torque;
      logic [VAL_W-1:0] final_monitor_torque;
   } fj_meas_s;

   typedef struct packed {
      logic final_monitor_under_fail;
      logic final_monitor_over_fail;
      logic selftap_torque_under_fail;
      logic selftap_torque_over_fail;
      logic rundown_angle_under_fail;
      logic rundown_angle_over_fail;
      logic peak_torque_under_fail;
      logic peak_torque_over_fail;
      logic final_current_under_fail;
      logic final_current_over_fail;
      logic seat_current_under_fail;
      logic seat_current_over_fail;
      logic seat_monitor_under_fail;
      logic seat_monitor_over_fail;
      logic overall_time_fail;
      logic final_max_time_fail;
      logic final_min_time_fail;
      logic preseat_time_fail;
      logic angle_under_fail;
      logic angle_over_fail;
      logic torque_under_fail;
      logic torque_over_fail;
      logic seat_torque_over_fail;
      logic spare1;
      logic spare0;
   } fj_fail_s;

   typedef enum logic [2:0] {
      FJ_IDLE    = 3'b001,
      FJ_RUNNING = 3'b010,
      FJ_DONE    = 3'b100
   } fj_state_e;
endpackage : fj_pkg

// ---- design/fj_judge.sv ----
// Fastening result judgement with limit registers, fail flags and APB access.
`timescale 1ns/1ps
module fj_judge (
   input  wire logic                    pclk,                  // Bus and core clock.
   input  wire logic                    presetn,               // Asynchronous reset, active low.
   input  wire logic                    psel,                  // APB select.
   input  wire logic                    penable,               // APB enable.
   input  wire logic                    pwrite,                // APB direction.
   input  wire logic [11:0]             paddr,                 // APB byte address.
   input  wire logic [31:0]             pwdata,                // APB write data.
   output logic      [31:0]             prdata,                // APB read data.
   output logic                         pready,                // APB ready.
   output logic                         pslverr,               // APB error on unmapped address.
   input  wire logic                    cycle_start,           // Pulse: fastening cycle begins.
   input  wire logic                    cycle_end,             // Pulse: measurements are final.
   input  wire logic                    cycle_abort,           // Pulse: cycle ended by system error.
   input  wire fj_pkg::fj_meas_s        meas,                  // Measured results of the cycle.
   input  wire logic [fj_pkg::JOB_W-1:0] job_select,           // Job number chosen upstream.
   input  wire logic                    spindles_judged,       // Pulse: total spindle judgement made.
   input  wire logic                    spindles_all_ok,       // Total spindle judgement is pass.
   output logic [fj_pkg::JOB_W-1:0]     job_answer,            // Job answer, bit 0 weight 1.
   output fj_pkg::fj_fail_s             fail,                  // Per-limit fail flags.
   output logic                         cycle_complete,        // Cycle has finished.
   output logic                         cycle_fail,            // Cycle judged as failed.
   output logic                         cycle_pass,            // Cycle judged as passed.
   output logic                         combined_spindles_ok,  // Combined spindle pass.
   output logic                         combined_spindles_fail,// Combined spindle fail.
   output logic                         irq                    // Level interrupt.
);
   // ========================================
   // Register state
   logic [31:0]                 ctrl;
   logic [fj_pkg::VAL_W-1:0]    limit [fj_pkg::NLIM];
   logic [fj_pkg::INT_W-1:0]    int_stat;
   logic [fj_pkg::INT_W-1:0]    int_mask;
   fj_pkg::fj_state_e           state;
   fj_pkg::fj_fail_s            next_fail;
   logic [fj_pkg::INT_W-1:0]    int_event;
   logic                        wr_en;
   logic                        setup;
   logic                        is_limit;
   logic [4:0]                  lim_idx;
   logic                        is_master;
   logic                        judge;

   function automatic logic over(input logic [fj_pkg::VAL_W-1:0] v,
                                 input logic [fj_pkg::VAL_W-1:0] lim);
      over = v > lim;
   endfunction : over

   function automatic logic under(input logic [fj_pkg::VAL_W-1:0] v,
                                  input logic [fj_pkg::VAL_W-1:0] lim);
      under = v < lim;
   endfunction : under

   assign setup    = psel & ~penable;
   assign wr_en    = psel & penable & pready & pwrite;
   assign is_limit = (paddr >= fj_pkg::LIMIT_BASE) &&
                     (paddr < fj_pkg::LIMIT_BASE + 12'(4 * fj_pkg::NLIM)) &&
                     (paddr[1:0] == 2'b00);
   assign lim_idx  = 5'((paddr - fj_pkg::LIMIT_BASE) >> 2);
   assign judge    = (state == fj_pkg::FJ_RUNNING) && cycle_end;
   assign is_master = ctrl[fj_pkg::CTRL_MULTI] &&
                      (ctrl[fj_pkg::CTRL_STN_LSB +: fj_pkg::STN_W] == fj_pkg::MASTER_STATION);

   // ========================================
   // Limit comparisons
   always_comb begin
      next_fail = '0;
      next_fail.seat_torque_over_fail =
         over(meas.seat_torque, limit[fj_pkg::L_SEAT_MAX]);
      next_fail.torque_over_fail  = over(meas.torque, limit[fj_pkg::L_TRQ_MAX]);
      next_fail.torque_under_fail = under(meas.torque, limit[fj_pkg::L_TRQ_MIN]);
      next_fail.angle_over_fail   = over(meas.angle, limit[fj_pkg::L_ANG_MAX]);
      next_fail.angle_under_fail  = under(meas.angle, limit[fj_pkg::L_ANG_MIN]);
      next_fail.preseat_time_fail =
         ~over(meas.preseat_time, limit[fj_pkg::L_PRESEAT_T]);
      next_fail.final_min_time_fail =
         ~over(meas.finish_time, limit[fj_pkg::L_FMIN_T]);
      next_fail.final_max_time_fail =
         over(meas.finish_time, limit[fj_pkg::L_FMAX_T]);
      next_fail.overall_time_fail =
         over(meas.total_time, limit[fj_pkg::L_TOTAL_T]);
      next_fail.peak_torque_over_fail =
         over(meas.peak_torque, limit[fj_pkg::L_PEAK_MAX]);
      next_fail.peak_torque_under_fail =
         under(meas.peak_torque, limit[fj_pkg::L_PEAK_MIN]);
      if (ctrl[fj_pkg::CTRL_SEAT_MON]) begin
         next_fail.seat_monitor_over_fail =
            over(meas.seat_monitor_torque, limit[fj_pkg::L_SMON_MAX]);
         next_fail.seat_monitor_under_fail =
            under(meas.seat_monitor_torque, limit[fj_pkg::L_SMON_MIN]);
      end
      if (ctrl[fj_pkg::CTRL_SEAT_CUR]) begin
         next_fail.seat_current_over_fail =
            over(meas.seat_current, limit[fj_pkg::L_SCUR_MAX]);
         next_fail.seat_current_under_fail =
            under(meas.seat_current, limit[fj_pkg::L_SCUR_MIN]);
      end
      if (ctrl[fj_pkg::CTRL_FIN_CUR]) begin
         next_fail.final_current_over_fail =
            over(meas.final_current, limit[fj_pkg::L_FCUR_MAX]);
         next_fail.final_current_under_fail =
            under(meas.final_current, limit[fj_pkg::L_FCUR_MIN]);
      end
      if (ctrl[fj_pkg::CTRL_RUNDOWN]) begin
         next_fail.rundown_angle_over_fail =
            over(meas.rundown_angle, limit[fj_pkg::L_RUN_MAX]);
         next_fail.rundown_angle_under_fail =
            under(meas.rundown_angle, limit[fj_pkg::L_RUN_MIN]);
      end
      if (ctrl[fj_pkg::CTRL_SELFTAP]) begin
         next_fail.selftap_torque_over_fail =
            over(meas.selftap_torque, limit[fj_pkg::L_STAP_MAX]);
         next_fail.selftap_torque_under_fail =
            under(meas.selftap_torque, limit[fj_pkg::L_STAP_MIN]);
      end
      if (ctrl[fj_pkg::CTRL_FIN_MON]) begin
         next_fail.final_monitor_over_fail =
            over(meas.final_monitor_torque, limit[fj_pkg::L_FMON_MAX]);
         next_fail.final_monitor_under_fail =
            under(meas.final_monitor_torque, limit[fj_pkg::L_FMON_MIN]);
      end
   end

   // ========================================
   // Cycle sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= fj_pkg::FJ_IDLE;
      end else begin
         case (state)
            fj_pkg::FJ_IDLE,
            fj_pkg::FJ_DONE: begin
               if (cycle_start) begin
                  state <= fj_pkg::FJ_RUNNING;
               end
            end
            fj_pkg::FJ_RUNNING: begin
               if (cycle_end || cycle_abort) begin
                  state <= fj_pkg::FJ_DONE;
               end
            end
            default: begin
               state <= fj_pkg::FJ_IDLE;
            end
         endcase
      end
   end

   // ========================================
   // Result flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail           <= '0;
         cycle_complete <= 1'b0;
         cycle_fail     <= 1'b0;
         cycle_pass     <= 1'b0;
      end else if (cycle_start && state != fj_pkg::FJ_RUNNING) begin
         fail           <= '0;
         cycle_complete <= 1'b0;
         cycle_fail     <= 1'b0;
         cycle_pass     <= 1'b0;
      end else if (judge) begin
         fail           <= next_fail;
         cycle_complete <= 1'b1;
         cycle_fail     <= |next_fail;
         cycle_pass     <= ~|next_fail;
      end else if (state == fj_pkg::FJ_RUNNING && cycle_abort) begin
         cycle_complete <= 1'b1;
         cycle_fail     <= 1'b1;
      end
   end

   // ========================================
   // Job answer and combined spindle result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         job_answer <= '0;
      end else begin
         job_answer <= job_select;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         combined_spindles_ok   <= 1'b0;
         combined_spindles_fail <= 1'b0;
      end else if (!is_master || (cycle_start && state != fj_pkg::FJ_RUNNING)) begin
         combined_spindles_ok   <= 1'b0;
         combined_spindles_fail <= 1'b0;
      end else if (spindles_judged) begin
         combined_spindles_ok   <= spindles_all_ok;
         combined_spindles_fail <= ~spindles_all_ok;
      end
   end

   // ========================================
   // Interrupts
   always_comb begin
      int_event = '0;
      int_event[fj_pkg::INT_COMPLETE] = (state == fj_pkg::FJ_RUNNING) &&
                                        (cycle_end || cycle_abort);
      int_event[fj_pkg::INT_FAIL] = (judge && |next_fail) ||
                                    (state == fj_pkg::FJ_RUNNING && !cycle_end && cycle_abort);
      int_event[fj_pkg::INT_COMBINED] = is_master && spindles_judged;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= '0;
      end else if (wr_en && paddr == fj_pkg::INT_STAT_OFS) begin
         int_stat <= (int_stat & ~pwdata[fj_pkg::INT_W-1:0]) | int_event;
      end else begin
         int_stat <= int_stat | int_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat & int_mask);
      end
   end

   // ========================================
   // Register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= fj_pkg::CTRL_RST;
         int_mask <= fj_pkg::INT_MASK_RST;
      end else if (wr_en) begin
         if (paddr == fj_pkg::CTRL_OFS) begin
            ctrl <= {16'h0000, pwdata[15:8], 1'b0, pwdata[6:0]};
         end
         if (paddr == fj_pkg::INT_MASK_OFS) begin
            int_mask <= pwdata[fj_pkg::INT_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < fj_pkg::NLIM; i++) begin
            limit[i] <= fj_pkg::LIMIT_RST;
         end
      end else if (wr_en && is_limit) begin
         limit[lim_idx] <= pwdata[fj_pkg::VAL_W-1:0];
      end
   end

   // ========================================
   // APB answer, one access cycle with no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (is_limit) begin
            prdata <= {16'h0000, limit[lim_idx]};
         end else begin
            case (paddr)
               fj_pkg::CTRL_OFS:     prdata <= ctrl;
               fj_pkg::FAIL_OFS:     prdata <= {7'h00, fail};
               fj_pkg::INT_STAT_OFS: prdata <= {29'h0, int_stat};
               fj_pkg::INT_MASK_OFS: prdata <= {29'h0, int_mask};
               fj_pkg::RESULT_OFS:   prdata <= {16'h0000, 1'b0, job_answer, 2'b00,
                                                combined_spindles_fail, combined_spindles_ok,
                                                cycle_pass, cycle_fail, cycle_complete,
                                                (state == fj_pkg::FJ_RUNNING)};
               default:              pslverr <= 1'b1;
            endcase
         end
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule : fj_judge

// ---- verification/fj_chk.sv ----
// Port checker of the fastening judgement block.
`timescale 1ns/1ps
module fj_chk (
   input wire logic                      pclk,                  // Clock.
   input wire logic                      presetn,               // Reset, active low.
   input wire logic                      psel,                  // APB select.
   input wire logic                      penable,               // APB enable.
   input wire logic                      pready,                // APB ready.
   input wire logic                      cycle_start,           // Cycle start pulse.
   input wire logic                      cycle_end,             // Cycle end pulse.
   input wire logic                      cycle_abort,           // Error end pulse.
   input wire logic [fj_pkg::JOB_W-1:0]  job_select,            // Job chosen.
   input wire logic [fj_pkg::JOB_W-1:0]  job_answer,            // Job answer.
   input wire fj_pkg::fj_fail_s          fail,                  // Fail flags.
   input wire logic                      cycle_complete,        // Cycle finished.
   input wire logic                      cycle_fail,            // Cycle failed.
   input wire logic                      cycle_pass,            // Cycle passed.
   input wire logic                      spindles_judged,       // Total judgement pulse.
   input wire logic                      combined_spindles_ok,  // Combined pass.
   input wire logic                      combined_spindles_fail // Combined fail.
);
   // ========================================
   // Helper state
   logic run;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run <= 1'b0;
      end else if (cycle_start && !run) begin
         run <= 1'b1;
      end else if (cycle_end || cycle_abort) begin
         run <= 1'b0;
      end
   end
   // ========================================
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_start; cycle_start && !run; endsequence
   sequence s_judge; cycle_end && run; endsequence
   property p_job; $past(presetn) |-> job_answer == $past(job_select); endproperty
   property p_clear; s_start |=> fail == '0 && !cycle_complete; endproperty
   property p_judge;
      s_judge |=> cycle_complete && cycle_fail == (fail != '0) && cycle_pass == (fail == '0);
   endproperty
   property p_abort; cycle_abort && run |=> cycle_complete && cycle_fail && fail == '0; endproperty
   property p_hold; !$stable(fail) |-> $past(cycle_start) || $past(cycle_end); endproperty
   property p_comb;
      $rose(combined_spindles_ok) || $rose(combined_spindles_fail) |-> $past(spindles_judged);
   endproperty
   property p_verdict; !(cycle_pass && cycle_fail); endproperty
   property p_ready; psel && !penable |=> pready; endproperty
   property p_ready_one; pready |=> !pready; endproperty
   a_job: assert property (p_job) else $error("job answer mismatch");
   a_clear: assert property (p_clear) else $error("flags not cleared at start");
   a_judge: assert property (p_judge) else $error("verdict mismatch");
   a_abort: assert property (p_abort) else $error("abort result wrong");
   a_hold: assert property (p_hold) else $error("flags changed mid cycle");
   a_comb: assert property (p_comb) else $error("combined result unprompted");
   a_verdict: assert property (p_verdict) else $error("pass and fail together");
   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
endmodule : fj_chk

bind fj_judge fj_chk fj_chk_i (.pclk, .presetn, .psel, .penable, .pready, .cycle_start,
   .cycle_end, .cycle_abort, .job_select, .job_answer, .fail, .cycle_complete, .cycle_fail,
   .cycle_pass, .spindles_judged, .combined_spindles_ok, .combined_spindles_fail);

// ---- verification/fj_spindle_agg.sv ----
// Far-side model: spindle aggregator that returns the total judgement.
`timescale 1ns/1ps
module fj_spindle_agg (
   input  wire logic       pclk,            // Clock.
   input  wire logic       presetn,         // Reset, active low.
   input  wire logic       ask,             // Pulse: judge now.
   input  wire logic       ask_ok,          // Verdict to return.
   input  wire logic [3:0] lag,             // Cycles before the answer.
   output logic            spindles_judged, // Pulse: judgement made.
   output logic            spindles_all_ok  // Verdict, valid with the pulse.
);
   logic [3:0] cnt;
   logic       busy;
   logic       ok;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {busy, cnt, ok, spindles_judged, spindles_all_ok} <= '0;
      end else begin
         spindles_judged <= 1'b0;
         // The verdict line is meaningless between answers, so it keeps toggling.
         spindles_all_ok <= !spindles_all_ok;
         if (ask) begin
            busy <= 1'b1;
            cnt  <= lag;
            ok   <= ask_ok;
         end else if (busy && cnt == 4'h0) begin
            busy            <= 1'b0;
            spindles_judged <= 1'b1;
            spindles_all_ok <= ok;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : fj_spindle_agg

// ---- verification/tb_top.sv ----
// Self-checking testbench of the fastening judgement block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]      paddr = '0;
   logic [31:0]      pwdata = '0, prdata, rd;
   logic             pready, pslverr, er, cycle_start = 1'b0, cycle_end = 1'b0;
   logic             cycle_abort = 1'b0, ask = 1'b0, ask_ok = 1'b0;
   logic [3:0]       lag = 4'h0;
   fj_pkg::fj_meas_s meas = '0;
   logic [6:0]       job_select = 7'h00, job_answer;
   fj_pkg::fj_fail_s fail;
   logic             cycle_complete, cycle_fail, cycle_pass, irq, spindles_judged;
   logic             combined_spindles_ok, combined_spindles_fail, spindles_all_ok;
   int               failures = 0, num_checks = 0;
   fj_judge fj_judge_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cycle_start, .cycle_end, .cycle_abort, .meas, .job_select,
      .spindles_judged, .spindles_all_ok, .job_answer, .fail, .cycle_complete, .cycle_fail,
      .cycle_pass, .combined_spindles_ok, .combined_spindles_fail, .irq);
   fj_spindle_agg fj_spindle_agg_i (.pclk, .presetn, .ask, .ask_ok, .lag, .spindles_judged,
      .spindles_all_ok);
   always #2.5 pclk = ~pclk;
   // ========================================
   // Shared tasks
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic settle;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : settle
   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
      `CHK("slverr", 1'b0, er)
   endtask : rdchk
   function automatic fj_pkg::fj_meas_s mk(input logic [15:0] v, p, f, t);
      mk = {13{v}};
      mk.preseat_time = p; mk.finish_time = f; mk.total_time = t;
   endfunction : mk
   task automatic cyc(input fj_pkg::fj_meas_s m, input logic ab);
      int n;
      @(posedge pclk); cycle_start <= 1'b1;
      @(posedge pclk); cycle_start <= 1'b0; meas <= m;
      @(posedge pclk); cycle_end <= !ab; cycle_abort <= ab;
      @(posedge pclk); cycle_end <= 1'b0; cycle_abort <= 1'b0;
      n = 0;
      while (cycle_complete !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
      @(negedge pclk);
      `CHK("complete", 1'b1, cycle_complete)
   endtask : cyc
   task automatic judge(input logic [31:0] c, input fj_pkg::fj_meas_s m, input logic [24:0] e);
      apb(1'b1, fj_pkg::CTRL_OFS, c);
      cyc(m, 1'b0);
      `CHK("fail flags", e, fail)
      `CHK("cycle fail", e != 25'h0, cycle_fail)
      `CHK("cycle pass", e == 25'h0, cycle_pass)
      rdchk("fail reg", fj_pkg::FAIL_OFS, {7'h00, e});
   endtask : judge
   task automatic comb(input logic [31:0] c, input logic ok, input logic [3:0] l,
                       input logic eo, input logic ef);
      int n;
      judge(c, mk(16'h64, 16'h15, 16'h3c, 16'h50), 25'h0);
      @(posedge pclk); ask <= 1'b1; ask_ok <= ok; lag <= l;
      @(posedge pclk); ask <= 1'b0;
      n = 0;
      while (spindles_judged !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
      settle;
      `CHK("combined ok", eo, combined_spindles_ok)
      `CHK("combined fail", ef, combined_spindles_fail)
   endtask : comb
   task report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // ========================================
   // Scenarios
   task t_reset;
      rdchk("ctrl", fj_pkg::CTRL_OFS, fj_pkg::CTRL_RST);
      rdchk("mask", fj_pkg::INT_MASK_OFS, 32'h0);
      rdchk("limit", fj_pkg::LIMIT_BASE, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      `CHK("fail reset", 25'h0, fail)
      $display("test reset done");
   endtask : t_reset
   task t_job;
      for (int i = 0; i < 7; i++) begin
         @(posedge pclk);
         job_select <= 7'h01 << i;
         settle;
         `CHK("job answer", 7'h01 << i, job_answer)
      end
      $display("test job done");
   endtask : t_job
   task t_judge;
      logic [31:0] v;
      for (int i = 0; i < 23; i++) begin
         case (i)
            5: v = 32'h14;
            6: v = 32'h1e;
            7: v = 32'h3c;
            8: v = 32'h50;
            default: v = (i >= 2 && i % 2 == 0) ? 32'h32 : 32'h64;
         endcase
         apb(1'b1, fj_pkg::LIMIT_BASE + 12'(4 * i), v);
      end
      rdchk("limit fmax", fj_pkg::LIMIT_BASE + 12'(4 * fj_pkg::L_FMAX_T), 32'h3c);
      judge(32'h13f, mk(16'h64, 16'h15, 16'h3c, 16'h50), 25'h0);
      judge(32'h13f, mk(16'h32, 16'h15, 16'h1f, 16'h0), 25'h0);
      // Every over-limit flag plus final maximum and total time.
      judge(32'h13f, mk(16'h65, 16'h15, 16'h3d, 16'h51), 25'h0aaae2c);
      // Every under-limit flag plus pre-seat and final minimum time.
      judge(32'h13f, mk(16'h31, 16'h14, 16'h1e, 16'h0), 25'h15551d0);
      judge(32'h100, mk(16'h65, 16'h15, 16'h3d, 16'h51), 25'h002062c);
      $display("test judge done");
   endtask : t_judge
   task t_abort;
      cyc(mk(16'h65, 16'h15, 16'h3d, 16'h51), 1'b1);
      `CHK("abort fail", 1'b1, cycle_fail)
      `CHK("abort flags", 25'h0, fail)
      rdchk("result", fj_pkg::RESULT_OFS, 32'h4006);
      $display("test abort done");
   endtask : t_abort
   task t_irq;
      apb(1'b1, fj_pkg::INT_MASK_OFS, 32'h7);
      apb(1'b1, fj_pkg::INT_STAT_OFS, 32'h7);
      settle;
      `CHK("irq cleared", 1'b0, irq)
      cyc(mk(16'h65, 16'h15, 16'h3d, 16'h51), 1'b0);
      settle;
      `CHK("irq raised", 1'b1, irq)
      rdchk("int stat", fj_pkg::INT_STAT_OFS, 32'h3);
      apb(1'b1, fj_pkg::INT_MASK_OFS, 32'h0);
      settle;
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, fj_pkg::INT_STAT_OFS, 32'h3);
      rdchk("int stat clr", fj_pkg::INT_STAT_OFS, 32'h0);
      $display("test irq done");
   endtask : t_irq
   task t_comb;
      comb(32'h140, 1'b1, 4'h3, 1'b1, 1'b0);
      comb(32'h140, 1'b0, 4'h0, 1'b0, 1'b1);
      comb(32'h240, 1'b1, 4'h0, 1'b0, 1'b0);
      $display("test comb done");
   endtask : t_comb
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_job;
      t_judge;
      t_abort;
      t_irq;
      t_comb;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      report_and_stop;
   end
endmodule : tb_top
